// *** rtl/mps_pkg.sv ***
// Package of constants and types for the motor parameter and start-up block
// Summary of operation
// - Back-EMF code decodes as low 4-bit mantissa shifted by top 3 bits.
// - Back-EMF code 7f decodes to 1920, the largest weighted value.
// - Back-EMF code 01 decodes to weighted value one.
// - Resistance codes use the mantissa-shift table; code 7f is largest.
// - Back-EMF codes follow the same table; code 18 decodes to 16.
// - Resistance LSB is 9.67 milliohm; mantissa shifted by exponent.
// - Start-up classifies motor stationary, forward or reverse.
// - Stationary motor uses position sensing or forced alignment.
// - Position sensing finds rotor position from inductance variation.
// - Forced alignment drives one phase so the rotor aligns first.
// - Fast forward spin with resync enabled enters closed loop at once.
// - Reverse drive accelerates a backward motor through zero speed.
// - Without reverse drive, backward motor waits to stop or is braked.
// - After a waiting reverse motor stops or the brake step reports done, stationary start path follows.
// - Braking is enabled only for a nonzero 3-bit brake duration.
// - Nonzero 4-bit sense current selects position sensing, else align.
package mps_pkg;
  localparam int          CODE_W      = 7;
  localparam int          MANT_W      = 4;
  localparam int          WEIGHT_W    = 11;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_CODES  = 12'h004;
  localparam logic [11:0] ADDR_MOTION = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_WEIGHT = 12'h010;
  localparam int          CTRL_GO     = 0;
  localparam int          CTRL_RESYNC = 1;
  localparam int          CTRL_REVDRV = 2;
  localparam int          CTRL_BRK_LSB = 4;
  localparam int          CTRL_SENSE_LSB = 8;
  localparam int          MOT_STOPPED = 0;
  localparam int          MOT_REVERSE = 1;
  localparam int          MOT_FAST    = 2;
  localparam int          MOT_DONE    = 3;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] CODES_RST   = 32'h0000_0000;
  localparam logic [31:0] MOTION_RST  = 32'h0000_0000;
  typedef enum logic [3:0] {
    MPS_IDLE, MPS_CLASSIFY, MPS_WAIT_STOP, MPS_BRAKE, MPS_SELECT,
    MPS_SENSE, MPS_ALIGN, MPS_REVDRV, MPS_ACCEL, MPS_CLOSED
  } mps_state_e;
endpackage

// *** rtl/mps_cfg_if.sv ***
// Interface carrying decoder codes and results
`timescale 1ns/1ps
interface mps_cfg_if;
  import mps_pkg::*;
  logic [CODE_W-1:0]   res_code;
  logic [CODE_W-1:0]   bemf_code;
  logic [WEIGHT_W-1:0] res_weight;
  logic [WEIGHT_W-1:0] bemf_weight;
  modport dec (input res_code, bemf_code, output res_weight, bemf_weight);
  modport top (output res_code, bemf_code, input res_weight, bemf_weight);
endinterface

// *** rtl/mps_decode.sv ***
// Registered mantissa-shift decoder for both motor codes
`timescale 1ns/1ps
module mps_decode
  import mps_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  mps_cfg_if.dec    cfg
);
  logic [WEIGHT_W-1:0] res_r;
  logic [WEIGHT_W-1:0] res_nxt;
  logic [WEIGHT_W-1:0] bemf_r;
  logic [WEIGHT_W-1:0] bemf_nxt;

  function automatic logic [WEIGHT_W-1:0] expand(input logic [CODE_W-1:0] c);
    logic [WEIGHT_W-1:0] m;
    m = {{(WEIGHT_W-MANT_W){1'b0}}, c[MANT_W-1:0]};
    return m << c[CODE_W-1:MANT_W];
  endfunction

  always_comb begin
    res_nxt  = expand(cfg.res_code);
    bemf_nxt = expand(cfg.bemf_code);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_r  <= '0;
      bemf_r <= '0;
    end else begin
      res_r  <= res_nxt;
      bemf_r <= bemf_nxt;
    end
  end

  assign cfg.res_weight  = res_r;
  assign cfg.bemf_weight = bemf_r;

  a_bemf_max_code: assert property (@(posedge pclk)
    disable iff (!presetn)
    cfg.bemf_code == 7'h7f |=> bemf_r == 11'h780)
    else $error("bemf max code wrong");
  a_bemf_one_code: assert property (@(posedge pclk)
    disable iff (!presetn)
    cfg.bemf_code == 7'h01 |=> bemf_r == 11'h001)
    else $error("bemf code one wrong");
  a_bemf_code_18: assert property (@(posedge pclk)
    disable iff (!presetn)
    cfg.bemf_code == 7'h18 |=> bemf_r == 11'h010)
    else $error("bemf code 18 wrong");
  a_res_max_code: assert property (@(posedge pclk)
    disable iff (!presetn)
    cfg.res_code == 7'h7f |=> res_r == 11'h780)
    else $error("res max code wrong");
  a_res_zero_code: assert property (@(posedge pclk)
    disable iff (!presetn)
    cfg.res_code == 7'h00 |=> res_r == 11'h000)
    else $error("res zero code wrong");
  a_res_shift_rel: assert property (@(posedge pclk)
    disable iff (!presetn)
    1'b1 |=> res_r == (11'($past(cfg.res_code[3:0]))
                        << $past(cfg.res_code[6:4])))
    else $error("res decode relation wrong");
endmodule // mps_decode

// *** rtl/mps_startup.sv ***
// Start-up path selector with APB register file
`timescale 1ns/1ps
module mps_startup
  import mps_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             drive_brake,
  output logic             drive_sense,
  output logic             drive_align,
  output logic             drive_reverse,
  output logic             drive_accel,
  output logic             drive_closed
);
  mps_cfg_if cfg ();

  logic [31:0]  ctrl_r, ctrl_nxt;
  logic [31:0]  codes_r, codes_nxt;
  logic [31:0]  motion_r, motion_nxt;
  logic [31:0]  rdata_r, rdata_nxt;
  logic         err_r, err_nxt;
  mps_state_e   state_r, state_nxt;
  logic         go_r, go_nxt;
  logic [5:0]   outs_r, outs_nxt;
  logic         wr_acc, rd_acc, mapped;
  logic [2:0]   brake_set;
  logic [3:0]   sense_set;

  mps_decode u_dec (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (cfg)
  );

  assign cfg.res_code  = codes_r[6:0];
  assign cfg.bemf_code = codes_r[14:8];
  assign brake_set     = ctrl_r[CTRL_BRK_LSB +: 3];
  assign sense_set     = ctrl_r[CTRL_SENSE_LSB +: 4];

  // Zero wait states; every access completes in its first access cycle
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign mapped = paddr == ADDR_CTRL || paddr == ADDR_CODES ||
                  paddr == ADDR_MOTION || paddr == ADDR_STATUS ||
                  paddr == ADDR_WEIGHT;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  always_comb begin
    ctrl_nxt   = ctrl_r;
    codes_nxt  = codes_r;
    motion_nxt = motion_r;
    rdata_nxt  = rdata_r;
    err_nxt    = 1'b0;
    // Start request self-clears once taken by the sequencer
    if (go_r) ctrl_nxt[CTRL_GO] = 1'b0;
    if (wr_acc) begin
      err_nxt = !mapped;
      unique case (paddr)
        ADDR_CTRL:   ctrl_nxt   = merge(ctrl_nxt, pwdata, pstrb);
        ADDR_CODES:  codes_nxt  = merge(codes_r, pwdata, pstrb) &
                                  32'h0000_7f7f;
        ADDR_MOTION: motion_nxt = merge(motion_r, pwdata, pstrb) &
                                  32'h0000_000f;
        default: ;
      endcase
    end
    if (rd_acc) begin
      unique case (paddr)
        ADDR_CTRL:   rdata_nxt = ctrl_r;
        ADDR_CODES:  rdata_nxt = codes_r;
        ADDR_MOTION: rdata_nxt = motion_r;
        ADDR_STATUS: rdata_nxt = {22'h0, outs_r, state_r};
        ADDR_WEIGHT: rdata_nxt = {5'h0, cfg.bemf_weight,
                                  5'h0, cfg.res_weight};
        default:     rdata_nxt = 32'h0;
      endcase
    end
    if (psel && !penable && !pwrite) err_nxt = !mapped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= CTRL_RST;
      codes_r  <= CODES_RST;
      motion_r <= MOTION_RST;
      rdata_r  <= 32'h0;
      err_r    <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      codes_r  <= codes_nxt;
      motion_r <= motion_nxt;
      rdata_r  <= rdata_nxt;
      err_r    <= err_nxt;
    end
  end

  assign prdata  = rdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (pwrite ? !mapped : err_r);

  always_comb begin
    state_nxt = state_r;
    go_nxt    = ctrl_r[CTRL_GO] && !go_r;
    unique case (state_r)
      MPS_IDLE:
        if (go_r) state_nxt = MPS_CLASSIFY;
      MPS_CLASSIFY: begin
        if (motion_r[MOT_STOPPED])
          state_nxt = MPS_SELECT;
        else if (!motion_r[MOT_REVERSE])
          state_nxt = (ctrl_r[CTRL_RESYNC] && motion_r[MOT_FAST]) ?
                      MPS_CLOSED : MPS_SELECT;
        else if (ctrl_r[CTRL_REVDRV])
          state_nxt = MPS_REVDRV;
        else if (brake_set != 3'h0)
          state_nxt = MPS_BRAKE;
        else
          state_nxt = MPS_WAIT_STOP;
      end
      MPS_WAIT_STOP:
        if (motion_r[MOT_STOPPED]) state_nxt = MPS_SELECT;
      MPS_BRAKE:
        if (motion_r[MOT_DONE]) state_nxt = MPS_SELECT;
      MPS_SELECT:
        state_nxt = (sense_set != 4'h0) ? MPS_SENSE : MPS_ALIGN;
      MPS_SENSE:
        if (motion_r[MOT_DONE]) state_nxt = MPS_ACCEL;
      MPS_ALIGN:
        if (motion_r[MOT_DONE]) state_nxt = MPS_ACCEL;
      MPS_REVDRV:
        if (motion_r[MOT_STOPPED]) state_nxt = MPS_ACCEL;
      MPS_ACCEL:
        if (motion_r[MOT_FAST]) state_nxt = MPS_CLOSED;
      MPS_CLOSED: ;
      default: state_nxt = MPS_IDLE;
    endcase
    // A fresh start request restarts the sequence from any state
    if (go_r && state_r != MPS_IDLE) state_nxt = MPS_CLASSIFY;
    outs_nxt = {state_nxt == MPS_CLOSED, state_nxt == MPS_ACCEL,
                state_nxt == MPS_REVDRV, state_nxt == MPS_ALIGN,
                state_nxt == MPS_SENSE,  state_nxt == MPS_BRAKE};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= MPS_IDLE;
      go_r    <= 1'b0;
      outs_r  <= 6'h0;
    end else begin
      state_r <= state_nxt;
      go_r    <= go_nxt;
      outs_r  <= outs_nxt;
    end
  end

  assign {drive_closed, drive_accel, drive_reverse,
          drive_align, drive_sense, drive_brake} = outs_r;

  a_select_sense: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_r == MPS_SELECT && sense_set != 4'h0 && !go_r
    |=> state_r == MPS_SENSE ##0 drive_sense)
    else $error("sense path not taken");
  a_select_align: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_r == MPS_SELECT && sense_set == 4'h0 && !go_r
    |=> state_r == MPS_ALIGN ##0 drive_align)
    else $error("align path not taken");
  a_no_brake_zero: assert property (@(posedge pclk)
    disable iff (!presetn)
    brake_set == 3'h0 && $stable(ctrl_r) |-> !drive_brake)
    else $error("brake with zero duration");
  a_resync_closed: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_r == MPS_CLASSIFY && !go_r && !motion_r[MOT_STOPPED] &&
    !motion_r[MOT_REVERSE] && motion_r[MOT_FAST] && ctrl_r[CTRL_RESYNC]
    |=> drive_closed)
    else $error("resync did not close loop");
  a_reverse_drive: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_r == MPS_CLASSIFY && !go_r && !motion_r[MOT_STOPPED] &&
    motion_r[MOT_REVERSE] && ctrl_r[CTRL_REVDRV]
    |=> drive_reverse)
    else $error("reverse drive not taken");
  a_wait_to_stop: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_r == MPS_WAIT_STOP && !go_r && !motion_r[MOT_STOPPED]
    |=> state_r == MPS_WAIT_STOP)
    else $error("left wait before stop");
  a_stop_then_sel: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_r == MPS_WAIT_STOP && !go_r && motion_r[MOT_STOPPED]
    |=> ##1 (drive_sense || drive_align))
    else $error("stationary path not resumed");
  a_classify_exits: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_r == MPS_CLASSIFY |=> state_r != MPS_CLASSIFY || $past(go_r))
    else $error("classify stalled");

  c_resync: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == MPS_CLASSIFY ##1 drive_closed);
  c_brake: cover property (@(posedge pclk) disable iff (!presetn)
    drive_brake ##[1:20] drive_sense);
  c_revdrv: cover property (@(posedge pclk) disable iff (!presetn)
    drive_reverse ##[1:20] drive_accel);
  c_align: cover property (@(posedge pclk) disable iff (!presetn)
    drive_align ##[1:20] drive_closed);
endmodule // mps_startup

// *** dv/mps_motor_model.sv ***
// Behavioural motor that answers the start-up drive outputs
`timescale 1ns/1ps
module mps_motor_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       load,
  input  wire logic [1:0] spin_in,
  input  wire logic [5:0] drive,
  output logic      [3:0] motion
);
  // Spin codes: 0 still, 1 slow forward, 2 fast forward, 3 backward
  logic [1:0] spin_r;
  logic [5:0] last_r;
  logic [3:0] cnt_r;
  logic [5:0] age_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spin_r <= 2'h0;
      last_r <= 6'h00;
      cnt_r  <= 4'h0;
      age_r  <= 6'h00;
    end else begin
      last_r <= drive;
      cnt_r  <= (drive != last_r) ? 4'h0 : cnt_r + {3'h0, cnt_r != 4'hf};
      age_r  <= load ? 6'h00 : age_r + {5'h0, age_r != 6'h3f};
      // A free backward motor coasts to rest; braking or driving is faster
      if (load)
        spin_r <= spin_in;
      else if (spin_r == 2'h3 && (age_r >= 6'h28 ||
               ((drive[3] | drive[0]) && cnt_r[3])))
        spin_r <= 2'h0;
      else if (drive[4] && cnt_r[3])
        spin_r <= 2'h2;
    end
  end

  // Step done only after the step has been held for eight cycles
  assign motion = {(|drive[2:0]) & cnt_r[3], spin_r == 2'h2,
                   spin_r == 2'h3, spin_r == 2'h0};
endmodule // mps_motor_model

// *** dv/motor_param_decode_startup_select_test.sv ***
// Self-checking bench for the motor code decoder and start-up selector
`timescale 1ns/1ps
module motor_param_decode_startup_select_test;
  import mps_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        load = 1'b0;
  logic        clr = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [1:0]  spin = 2'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  drv;
  logic [5:0]  seen = 6'h00;
  logic [3:0]  motion;
  int          n_errors = 0;
  int          total_checks = 0;

  always #2.5 pclk = ~pclk;

  mps_startup dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_brake(drv[0]), .drive_sense(drv[1]), .drive_align(drv[2]),
    .drive_reverse(drv[3]), .drive_accel(drv[4]), .drive_closed(drv[5]));
  mps_motor_model motor_u (.pclk(pclk), .presetn(presetn), .load(load),
    .spin_in(spin), .drive(drv), .motion(motion));

  // Every drive step seen since the last start
  always @(posedge pclk) seen <= clr ? 6'h00 : (seen | drv);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One transfer plus an idle cycle; entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      n_errors++;
      give_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, 4'hf, q, e);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, q, e);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic sc_regs;
    logic [31:0] q;
    logic        e;
    rd(ADDR_CTRL, q);
    chk(q, CTRL_RST);
    rd(ADDR_CODES, q);
    chk(q, CODES_RST);
    rd(ADDR_MOTION, q);
    chk(q, MOTION_RST);
    wr(ADDR_CODES, 32'hffff_ffff);
    rd(ADDR_CODES, q);
    chk(q, 32'h0000_7f7f);
    apb(1'b1, ADDR_CODES, 32'h0000_0000, 4'h2, q, e);
    rd(ADDR_CODES, q);
    chk(q, 32'h0000_007f);
    apb(1'b0, 12'h020, 32'h0, 4'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'h024, 32'hffff_ffff, 4'hf, q, e);
    chk({31'h0, e}, 32'h1);
    rd(ADDR_CTRL, q);
    chk(q, 32'h0);
  endtask

  task automatic sc_decode;
    logic [6:0]  cd [6] = '{7'h00, 7'h01, 7'h03, 7'h18, 7'h5a,
                            7'h7f};
    logic [10:0] wt [6] = '{11'h0, 11'h1, 11'h3, 11'h10, 11'h140, 11'h780};
    logic [31:0] q;
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CODES, {17'h0, cd[5-i], 1'b0, cd[i]});
      rd(ADDR_WEIGHT, q);
      chk(q & 32'h0000_ffff, {21'h0, wt[i]});
      chk(q >> 16, {21'h0, wt[5-i]});
    end
  endtask

  // Start with the motor in a given state, then follow it to closed loop
  task automatic run_start(input logic [11:0] cfg, input logic [1:0] sp,
                           input logic [3:0] st, input logic [5:0] path);
    logic [31:0] q;
    logic [5:0]  ex;
    int          i;
    // One drive pin per active step; idle and decision steps drive none
    ex = (st == 4'h3) ? 6'h01 :
         (st > 4'h4) ? 6'h01 << (st - 4'h4) : 6'h00;
    spin <= sp;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    @(posedge pclk);
    wr(ADDR_MOTION, {28'h0, motion});
    clr <= 1'b1;
    wr(ADDR_CTRL, {20'h0, cfg} | 32'h1);
    // Hold clear until the old closed-loop pin has dropped
    @(posedge pclk);
    clr <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(ADDR_STATUS, q);
    chk(q & 32'h0000_000f, {28'h0, st});
    chk(q >> 4, {26'h0, ex});
    chk({26'h0, drv}, {26'h0, ex});
    for (i = 0; i < 200 && drv[5] !== 1'b1; i++)
      wr(ADDR_MOTION, {28'h0, motion});
    if (i >= 200) begin
      n_errors++;
      give_verdict();
    end
    repeat (2) @(posedge pclk);
    chk({26'h0, seen}, {26'h0, path});
  endtask

  task automatic sc_stop_sense;
    run_start(12'h800, 2'h0, 4'h5, 6'b110010);
  endtask
  task automatic sc_stop_align;
    run_start(12'h076, 2'h0, 4'h6, 6'b110100);
  endtask
  task automatic sc_fwd_resync;
    run_start(12'h002, 2'h2, 4'h9, 6'b100000);
  endtask
  task automatic sc_fwd_noresync;
    run_start(12'h100, 2'h2, 4'h5, 6'b110010);
  endtask
  task automatic sc_fwd_slow;
    run_start(12'h002, 2'h1, 4'h6, 6'b110100);
  endtask
  task automatic sc_rev_drive;
    run_start(12'h034, 2'h3, 4'h7, 6'b111000);
  endtask
  task automatic sc_rev_brake;
    run_start(12'h140, 2'h3, 4'h3, 6'b110011);
  endtask
  task automatic sc_rev_wait;
    run_start(12'h000, 2'h3, 4'h2, 6'b110100);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sc_regs();
    sc_decode();
    sc_stop_sense();
    sc_stop_align();
    sc_fwd_resync();
    sc_fwd_noresync();
    sc_fwd_slow();
    sc_rev_drive();
    sc_rev_brake();
    sc_rev_wait();
    give_verdict();
  end
endmodule // motor_param_decode_startup_select_test
